// File: core/e1dl_top.sv
// Receive data-link, multiframe and backplane timing of the E1 framer
`timescale 1ns/1ps
module e1dl_top (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Decoded receive bits from the line decoder
    input  wire logic                  rx_bit_valid,
    output logic                       rx_bit_ready,
    input  wire e1dl_pkg::e1dl_bit_t   rx_bit,
    // Configuration
    input  wire logic [2:0]            rx_link_rate_select,
    input  wire logic                  rx_multiframe_source_select,
    input  wire logic                  frame_pulse_format_select,
    // Receive pins
    output logic                       recovered_line_clock,
    output logic                       rx_line_data_out,
    output logic                       rx_link_bit_clock,
    output logic                       rx_multiframe_pulse,
    // Transmit multiframe alignment
    input  wire logic                  tx_multiframe_align_n,
    output logic                       tx_multiframe_start,
    output logic [3:0]                 tx_frame_number,
    // Backplane timing pins
    input  wire logic                  bus_or_line_sync_select,
    input  wire logic                  backplane_clock_4m_i,
    output e1dl_pkg::e1dl_pin_t        backplane_clock_4m,
    input  wire logic                  backplane_frame_pulse_i,
    output e1dl_pkg::e1dl_pin_t        backplane_frame_pulse
);
    import e1dl_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [3:0] pins_sync;
    logic       align_n_s;
    logic       bus_sync_s;
    logic       bp_clk_s;
    logic       bp_fp_s;

    e1dl_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({tx_multiframe_align_n, bus_or_line_sync_select,
                    backplane_clock_4m_i, backplane_frame_pulse_i}),
        .sync_out (pins_sync)
    );

    assign align_n_s  = pins_sync[3];
    assign bus_sync_s = pins_sync[2];
    assign bp_clk_s   = pins_sync[1];
    assign bp_fp_s    = pins_sync[0];

    // ****************************************************************
    // Receive bit buffer
    // ****************************************************************
    logic      fifo_valid;
    logic      fifo_pop;
    e1dl_bit_t fifo_bit;

    // Full buffer stalls the decoder through rx_bit_ready
    e1dl_fifo #(
        .WIDTH ($bits(e1dl_bit_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (rx_bit_valid),
        .in_ready  (rx_bit_ready),
        .in_data   (rx_bit),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_bit)
    );

    // ****************************************************************
    // Recovered clock and serial data pacing
    // ****************************************************************
    e1dl_state_t state;
    e1dl_state_t next_state;
    logic [3:0]  pace_cnt;
    logic [3:0]  next_pace_cnt;
    logic [7:0]  bit_idx;
    logic [7:0]  next_bit_idx;
    logic [7:0]  pop_idx;
    logic [2:0]  rate_code;
    logic        link_gate;
    logic        next_line_clock;
    logic        next_line_data;
    logic        next_link_clock;
    logic        next_mf_pulse;

    // Codes above 20 kHz clamp to the highest rate
    assign rate_code = (rx_link_rate_select > 3'(RATE_MAX_CODE))
                     ? 3'(RATE_MAX_CODE) : rx_link_rate_select;

    // Pop when idle or when the previous bit period has run out
    assign fifo_pop = fifo_valid &&
        ((state == E1DL_IDLE) ||
         ((state == E1DL_LOW) && (pace_cnt == 4'(LINE_BIT_CYCLES - 1))));

    // Index of the head bit; kept out of the pacing process to avoid a
    // loop, and a restart from idle still honours frame_start
    assign pop_idx = fifo_bit.frame_start ? 8'h00 : bit_idx + 8'h01;

    // Link bits are Sa4 upward in timeslot 0 of non-FAS frames
    assign link_gate = fifo_bit.non_fas &&
        (pop_idx >= 8'(SA_FIRST_BIT)) &&
        (pop_idx <= 8'(SA_FIRST_BIT) + 8'(rate_code));

    // Pacing state, bit position and output bits
    always_comb
    begin
        next_state      = state;
        next_pace_cnt   = pace_cnt;
        next_bit_idx    = bit_idx;
        next_line_clock = recovered_line_clock;
        next_line_data  = rx_line_data_out;
        next_link_clock = rx_link_bit_clock;
        next_mf_pulse   = rx_multiframe_pulse;
        if (fifo_bit.frame_start)
            next_bit_idx = '0;
        else
            next_bit_idx = bit_idx + 1'b1;
        case (state)
            E1DL_IDLE:
            begin
                next_bit_idx = bit_idx;
            end
            E1DL_HIGH:
            begin
                next_bit_idx  = bit_idx;
                next_pace_cnt = pace_cnt + 1'b1;
                if (pace_cnt == 4'(LINE_HIGH_CYCLES - 1))
                begin
                    next_state      = E1DL_LOW;
                    next_line_clock = 1'b0;
                    next_link_clock = 1'b0;
                end
            end
            E1DL_LOW:
            begin
                next_pace_cnt = pace_cnt + 1'b1;
                if (!fifo_pop)
                    next_bit_idx = bit_idx;
                if (pace_cnt == 4'(LINE_BIT_CYCLES - 1) && !fifo_valid)
                    next_state = E1DL_IDLE;
            end
            default:
            begin
                next_state   = E1DL_IDLE;
                next_bit_idx = bit_idx;
            end
        endcase
        if (fifo_pop)
        begin
            next_state      = E1DL_HIGH;
            next_pace_cnt   = '0;
            next_bit_idx    = pop_idx;
            next_line_clock = 1'b1;
            next_line_data  = fifo_bit.data;
            next_link_clock = link_gate;
            if (fifo_bit.frame_start)
                next_mf_pulse = rx_multiframe_source_select
                              ? fifo_bit.crc_mf_last
                              : fifo_bit.cas_mf_last;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state                <= E1DL_IDLE;
            pace_cnt             <= '0;
            bit_idx              <= '0;
            recovered_line_clock <= 1'b0;
            rx_line_data_out     <= 1'b0;
            rx_link_bit_clock    <= 1'b0;
            rx_multiframe_pulse  <= 1'b0;
        end
        else
        begin
            state                <= next_state;
            pace_cnt             <= next_pace_cnt;
            bit_idx              <= next_bit_idx;
            recovered_line_clock <= next_line_clock;
            rx_line_data_out     <= next_line_data;
            rx_link_bit_clock    <= next_link_clock;
            rx_multiframe_pulse  <= next_mf_pulse;
        end
    end

    // ****************************************************************
    // Backplane clock and frame pulse
    // ****************************************************************
    logic [3:0] half_cnt;
    logic [3:0] next_half_cnt;
    logic       bp_clk;
    logic       next_bp_clk;
    logic [8:0] bp_count;
    logic [8:0] next_bp_count;
    logic       bp_clk_d;
    logic       bp_fp_d;
    logic       fp_active;
    logic       fp_seen;
    logic       drive_bp;
    logic       frame_tick;

    // Sync select high hands backplane timing to the bus master
    assign drive_bp = !bus_sync_s;
    assign fp_active = (bp_count == 9'(BP_CLKS_PER_FRAME - 1));

    // GCI pulse is active high, the other style active low
    assign backplane_clock_4m.o     = bp_clk;
    assign backplane_clock_4m.oe    = drive_bp;
    assign backplane_frame_pulse.o  = frame_pulse_format_select
                                    ? fp_active : !fp_active;
    assign backplane_frame_pulse.oe = drive_bp;

    // External pulse sampled on the synced clock rise, by style
    assign fp_seen = (bp_clk_s && !bp_clk_d) &&
        (frame_pulse_format_select ? (bp_fp_s && !bp_fp_d)
                                   : (!bp_fp_s && bp_fp_d));
    assign frame_tick = drive_bp
        ? (fp_active && bp_clk && half_cnt == 4'(BP_HALF_CYCLES - 1))
        : fp_seen;

    // Own divider keeps running so a mode change starts cleanly
    always_comb
    begin
        next_half_cnt = half_cnt + 1'b1;
        next_bp_clk   = bp_clk;
        next_bp_count = bp_count;
        if (half_cnt == 4'(BP_HALF_CYCLES - 1))
        begin
            next_half_cnt = '0;
            next_bp_clk   = !bp_clk;
            if (bp_clk)
                next_bp_count = (bp_count == 9'(BP_CLKS_PER_FRAME - 1))
                              ? '0 : bp_count + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            half_cnt <= '0;
            bp_clk   <= 1'b0;
            bp_count <= BP_COUNT_RESET;
            bp_clk_d <= 1'b0;
            bp_fp_d  <= 1'b0;
        end
        else
        begin
            half_cnt <= next_half_cnt;
            bp_clk   <= next_bp_clk;
            bp_count <= next_bp_count;
            bp_clk_d <= bp_clk_s;
            bp_fp_d  <= bp_fp_s;
        end
    end

    // ****************************************************************
    // Transmit multiframe alignment
    // ****************************************************************
    logic       align_n_d;
    logic [3:0] next_tx_frame;
    logic       next_tx_start;

    // Falling edge of the alignment input restarts at frame zero
    always_comb
    begin
        next_tx_frame = tx_frame_number;
        next_tx_start = 1'b0;
        if (!align_n_s && align_n_d)
        begin
            next_tx_frame = '0;
            next_tx_start = 1'b1;
        end
        else if (frame_tick)
        begin
            next_tx_frame = (tx_frame_number == 4'(MF_FRAMES - 1))
                          ? '0 : tx_frame_number + 1'b1;
            next_tx_start = (tx_frame_number == 4'(MF_FRAMES - 1));
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            align_n_d           <= 1'b0; // Synced pin is 0 in reset
            tx_frame_number     <= TX_FRAME_RESET;
            tx_multiframe_start <= 1'b0;
        end
        else
        begin
            align_n_d           <= align_n_s;
            tx_frame_number     <= next_tx_frame;
            tx_multiframe_start <= next_tx_start;
        end
    end
endmodule

// File: core/e1dl_pkg.sv
// Constants and carrier types of the E1 receive data-link timing block
// ****************************************************************
// ****************************************************************
package e1dl_pkg;

    // Clock and line timing
    localparam int CLK_NS          = 100;
    localparam int LINE_BIT_NS     = 488;
    localparam int LINE_BIT_CYCLES =
        (LINE_BIT_NS / CLK_NS) < 1 ? 1 : (LINE_BIT_NS / CLK_NS);
    localparam int LINE_HIGH_NS    = 244;
    localparam int LINE_HIGH_CYCLES =
        (LINE_HIGH_NS / CLK_NS) < 1 ? 1 : (LINE_HIGH_NS / CLK_NS);
    localparam int BP_HALF_NS      = 122;
    localparam int BP_HALF_CYCLES  =
        (BP_HALF_NS / CLK_NS) < 1 ? 1 : (BP_HALF_NS / CLK_NS);

    // Frame structure
    localparam int BP_CLKS_PER_FRAME = 512;
    localparam int MF_FRAMES         = 16;
    localparam int SA_FIRST_BIT      = 3;
    localparam int RATE_MAX_CODE     = 4;
    localparam int FIFO_DEPTH        = 8;

    // Reset values
    localparam logic [3:0] TX_FRAME_RESET = 4'h0;
    localparam logic [8:0] BP_COUNT_RESET = 9'h000;

    // One decoded receive bit with its frame position marks
    typedef struct packed {
        logic frame_start;
        logic non_fas;
        logic crc_mf_last;
        logic cas_mf_last;
        logic data;
    } e1dl_bit_t;

    // Two signals of one two-way pin, outward half
    typedef struct packed {
        logic o;
        logic oe;
    } e1dl_pin_t;

    // Output pacing states
    typedef enum logic [2:0] {
        E1DL_IDLE = 3'b001,
        E1DL_HIGH = 3'b010,
        E1DL_LOW  = 3'b100
    } e1dl_state_t;

endpackage

// File: core/e1dl_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module e1dl_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    // First stage is read only by the second
    always_comb
    begin
        next_meta = async_in;
        next_sync = meta;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= next_meta;
            sync_out <= next_sync;
        end
    end
endmodule

// File: core/e1dl_fifo.sv
// Bit FIFO between the line decoder and the output pacing
`timescale 1ns/1ps
module e1dl_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    // Honest full and empty from the fill count
    assign in_ready  = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update, wrapping at any depth
    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push)
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        if (pop)
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        if (push && !pop)
            next_count = count + 1'b1;
        else if (pop && !push)
            next_count = count - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage needs no reset
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
endmodule

// File: test/e1dl_checker.sv
// Port assertions of the E1 receive timing block
`timescale 1ns/1ps
module e1dl_checker (
    // Clock and reset
    input wire logic                clk,
    input wire logic                rst,
    // Receive pins
    input wire logic                recovered_line_clock,
    input wire logic                rx_line_data_out,
    input wire logic                rx_link_bit_clock,
    input wire logic                rx_multiframe_pulse,
    // Transmit alignment
    input wire logic                tx_multiframe_align_n,
    input wire logic                tx_multiframe_start,
    input wire logic [3:0]          tx_frame_number,
    // Backplane pins
    input wire logic                bus_or_line_sync_select,
    input wire e1dl_pkg::e1dl_pin_t backplane_clock_4m,
    input wire e1dl_pkg::e1dl_pin_t backplane_frame_pulse
);
    import e1dl_pkg::*;
    // ********
    // Clocking
    // ********
    // One domain only, so clock and reset are given once
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // ********
    // Checks
    // ********
    data_edge_a: assert property (
        $changed(rx_line_data_out) |-> $rose(recovered_line_clock))
        else $error("data moved off a line clock rise");
    gapped_clock_a: assert property (
        rx_link_bit_clock |-> recovered_line_clock)
        else $error("link clock high outside a line clock pulse");
    line_pace_a: assert property (
        $rose(recovered_line_clock) |=> recovered_line_clock
        ##1 !recovered_line_clock [*2])
        else $error("line clock not two high then two low");
    mf_edge_a: assert property (
        $changed(rx_multiframe_pulse) |->
        $rose(recovered_line_clock) && !rx_link_bit_clock)
        else $error("multiframe pulse moved off a frame start");
    align_start_a: assert property (
        $fell(tx_multiframe_align_n) |-> ##[2:5] tx_multiframe_start)
        else $error("alignment low gave no multiframe start");
    start_zero_a: assert property (
        tx_multiframe_start |-> tx_frame_number == 4'h0)
        else $error("multiframe start away from frame zero");
    frame_step_a: assert property (
        $changed(tx_frame_number) |-> tx_multiframe_start ||
        tx_frame_number == $past(tx_frame_number) + 4'h1)
        else $error("transmit frame number skipped");
    pins_in_a: assert property (
        bus_or_line_sync_select [*5] |->
        !backplane_clock_4m.oe && !backplane_frame_pulse.oe)
        else $error("backplane pins driven in bus mode");
    pins_out_a: assert property (
        (!bus_or_line_sync_select) [*5] |->
        backplane_clock_4m.oe && backplane_frame_pulse.oe)
        else $error("backplane pins not driven in line mode");
    bp_toggle_a: assert property (
        !$past(rst) && backplane_clock_4m.oe ##1 backplane_clock_4m.oe
        |-> $changed(backplane_clock_4m.o))
        else $error("driven backplane clock stalled");
    // Main scenarios reached
    cover property ($rose(rx_multiframe_pulse));
    cover property ($rose(rx_link_bit_clock));
    cover property (tx_multiframe_start);
endmodule

bind e1dl_top e1dl_checker u_e1dl_checker (.*);

// File: test/e1dl_far_model.sv
// Far side: link receiver and backplane timing master
`timescale 1ns/1ps
module e1dl_far_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Receive pins
    input  wire logic       recovered_line_clock,
    input  wire logic       rx_line_data_out,
    input  wire logic       rx_link_bit_clock,
    input  wire logic       rx_multiframe_pulse,
    input  wire logic       frame_pulse_format_select,
    // Captured bit: data, link mark, multiframe mark
    output logic            bit_seen,
    output logic      [2:0] bit_word,
    // Backplane master drive
    output logic            far_clk,
    output logic            far_pulse,
    output logic            far_mid
);
    import e1dl_pkg::*;
    logic       line_q;
    logic [6:0] far_cnt;
    logic [6:0] far_ph;
    // ********
    // Capture
    // ********
    // All taken at the line clock rise, as a real receiver would
    always_ff @(posedge clk)
    begin
        line_q   <= recovered_line_clock;
        bit_seen <= recovered_line_clock && !line_q;
        bit_word <= {rx_line_data_out, rx_link_bit_clock,
                     rx_multiframe_pulse};
    end
    // ********
    // Master
    // ********
    // Short 32-clock frames keep the bus mode runs brief
    always_ff @(posedge clk)
    begin
        if (rst)
            far_cnt <= 7'h00;
        else
            far_cnt <= far_cnt + 7'h01;
    end
    assign far_clk   = far_cnt[1];
    // Pulse edges fall on a clock rise, where the design looks for them
    assign far_ph    = far_cnt + 7'h02;
    assign far_pulse = (far_ph[6:2] == 5'h1F) ==
                       frame_pulse_format_select;
    assign far_mid   = far_cnt == 7'h40;
endmodule

// File: test/e1_datalink_multiframe_timing_bench.sv
// Self-checking bench of the E1 receive timing block
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
        end \
    end
module e1_datalink_multiframe_timing_bench;
    import e1dl_pkg::*;
    localparam int DLY = 10;
    logic       clk;
    logic       rst;
    logic       rx_bit_valid;
    logic       rx_bit_ready;
    e1dl_bit_t  rx_bit;
    logic [2:0] rx_link_rate_select;
    logic       rx_multiframe_source_select;
    logic       frame_pulse_format_select;
    logic       recovered_line_clock;
    logic       rx_line_data_out;
    logic       rx_link_bit_clock;
    logic       rx_multiframe_pulse;
    logic       tx_multiframe_align_n;
    logic       tx_multiframe_start;
    logic [3:0] tx_frame_number;
    logic       bus_or_line_sync_select;
    logic       backplane_clock_4m_i;
    e1dl_pin_t  backplane_clock_4m;
    logic       backplane_frame_pulse_i;
    e1dl_pin_t  backplane_frame_pulse;
    logic       bit_seen;
    logic [2:0] bit_word;
    logic       far_clk;
    logic       far_pulse;
    logic       far_mid;
    logic [2:0] exp_w;
    logic [2:0] exp_q[$];
    int         miscompares;
    int         total_checks;
    int         refused;
    // ********
    // Wiring
    // ********
    // Pin level: design when enabled, else far master or a moving level
    assign backplane_clock_4m_i = backplane_clock_4m.oe ?
        backplane_clock_4m.o :
        (bus_or_line_sync_select ? far_clk : ~backplane_clock_4m.o);
    assign backplane_frame_pulse_i = backplane_frame_pulse.oe ?
        backplane_frame_pulse.o :
        (bus_or_line_sync_select ? far_pulse : ~backplane_frame_pulse.o);
    e1dl_top       u_e1dl_top (.*);
    e1dl_far_model u_e1dl_far_model (.*);
    // 10 MHz clock
    initial
    begin
        clk = 1'b0;
        forever
            #50 clk = ~clk;
    end
    // Each captured bit against the next expected word
    always @(posedge clk)
    begin
        if (bit_seen)
        begin
            exp_w = exp_q.size() > 0 ? exp_q.pop_front() : ~bit_word;
            `CHK(bit_word, exp_w)
        end
    end
    // ********
    // Tasks
    // ********
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #DLY;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic expire();
        miscompares++;
        $display("[ERR] %0t wait ran out got %h exp %h", $time, 0, 1);
        give_verdict();
    endtask
    task automatic wait_start(input int lim, output int n);
        n = 0;
        while (tx_multiframe_start !== 1'b1 && n < lim)
        begin
            n++;
            cyc(1);
        end
        if (n == lim)
            expire();
    endtask
    // One bit through valid/ready; counts refused cycles
    task automatic push_bit(input e1dl_bit_t b);
        int n;
        rx_bit = b;
        rx_bit_valid = 1'b1;
        n = 0;
        while (rx_bit_ready !== 1'b1 && n < 50)
        begin
            refused++;
            n++;
            cyc(1);
        end
        if (n == 50)
            expire();
        cyc(1);
    endtask
    task automatic check_reset();
        `CHK(tx_frame_number, 4'h0)
        `CHK(recovered_line_clock | rx_link_bit_clock, 1'b0)
        `CHK(rx_multiframe_pulse | rx_line_data_out, 1'b0)
        `CHK({backplane_clock_4m.oe, backplane_frame_pulse.oe}, 2'h3)
        `CHK(backplane_frame_pulse.o, 1'b1)
    endtask
    // Exactly one frame pulse between two frame ticks
    task automatic fp_check(input logic g);
        logic [3:0] f;
        logic       act;
        logic       was;
        int         n;
        int         starts;
        frame_pulse_format_select = g;
        for (int k = 0; k < 2; k++)
        begin
            f = tx_frame_number;
            n = 0;
            starts = 0;
            was = 1'b1;
            while (tx_frame_number === f && n < 2100)
            begin
                act = backplane_frame_pulse.o === g;
                starts += int'(act && !was);
                was = act;
                n++;
                cyc(1);
            end
            if (n == 2100)
                expire();
        end
        `CHK(starts, 1)
    endtask
    task automatic tx_align();
        int n;
        wait_start(20000, n);
        `CHK(tx_frame_number, 4'h0)
        cyc(2500);
        tx_multiframe_align_n = 1'b0;
        wait_start(8, n);
        `CHK(n >= 2, 1'b1)
        cyc(1);
        n = 0;
        repeat (300)
        begin
            n += int'(tx_multiframe_start);
            cyc(1);
        end
        `CHK(n, 0)
        tx_multiframe_align_n = 1'b1;
    endtask
    // Far master drives the pins; one tick per far frame
    task automatic input_mode();
        logic [3:0] f;
        bus_or_line_sync_select = 1'b1;
        cyc(5);
        `CHK({backplane_clock_4m.oe, backplane_frame_pulse.oe}, 2'h0)
        for (int g = 0; g < 2; g++)
        begin
            frame_pulse_format_select = 1'(g);
            cyc(130);
            for (int k = 0; k < 130 && far_mid !== 1'b1; k++)
                cyc(1);
            if (far_mid !== 1'b1)
                expire();
            f = tx_frame_number;
            cyc(512);
            `CHK(tx_frame_number, f + 4'h4)
        end
        bus_or_line_sync_select = 1'b0;
        cyc(5);
        `CHK({backplane_clock_4m.oe, backplane_frame_pulse.oe}, 2'h3)
    endtask
    // Sixteen full frames; rate codes 0..5 on the odd frames
    task automatic send_mf(input logic src);
        e1dl_bit_t  b;
        logic [2:0] c;
        logic       lk;
        int         n;
        rx_multiframe_source_select = src;
        refused = 0;
        for (int f = 0; f < 16; f++)
        begin
            c = 3'((f / 2) % 6);
            rx_link_rate_select = c;
            for (int i = 0; i < 256; i++)
            begin
                b = '{i == 0, f % 2 == 1, i == 0 && f == 15,
                      i == 0 && f == 7, (i + f) % 3 == 0};
                lk = f % 2 == 1 && i >= 3 &&
                     i <= 3 + (c > 3'h4 ? 4 : int'(c));
                exp_q.push_back({b.data, lk, src ? f == 15 : f == 7});
                push_bit(b);
            end
        end
        rx_bit_valid = 1'b0;
        n = 0;
        while (exp_q.size() > 0 && n < 200)
        begin
            n++;
            cyc(1);
        end
        if (n == 200)
            expire();
        `CHK(refused > 0, 1'b1)
    endtask
    // ********
    // Sequence
    // ********
    initial
    begin
        rst = 1'b1;
        rx_bit_valid = 1'b0;
        rx_bit = '0;
        rx_link_rate_select = 3'h0;
        rx_multiframe_source_select = 1'b1;
        frame_pulse_format_select = 1'b0;
        tx_multiframe_align_n = 1'b1;
        bus_or_line_sync_select = 1'b0;
        miscompares = 0;
        total_checks = 0;
        refused = 0;
        cyc(3);
        rst = 1'b0;
        check_reset();
        fp_check(1'b0);
        fp_check(1'b1);
        tx_align();
        input_mode();
        send_mf(1'b1);
        send_mf(1'b0);
        give_verdict();
    end
endmodule
